/* File: btrr_pkg.sv */
package btrr_pkg;
   // Instruction field layout, with bit 0 as the least significant bit of the word
   localparam int INSN_W = 32;
   localparam int ADDR_W = 32;
   localparam logic [5:0] OPC_BRANCH_REG = 6'h13;
   localparam logic [9:0] XO_TO_LINK = 10'h010;
   localparam logic [9:0] XO_TO_COUNT = 10'h210;
   localparam int OPC_HI = 31;
   localparam int OPC_LO = 26;
   localparam int OPT_HI = 25;
   localparam int OPT_LO = 21;
   localparam int SEL_HI = 20;
   localparam int SEL_LO = 16;
   localparam int XO_HI = 10;
   localparam int XO_LO = 1;
   localparam int LINK_BIT = 0;
   // Option bits as indices into the five-bit options vector; index 4 is the first field bit
   localparam int OPT_IGNORE_COND = 4;
   localparam int OPT_COND_SENSE = 3;
   localparam int OPT_KEEP_COUNT = 2;
   localparam int OPT_ZERO_SENSE = 1;
   localparam int OPT_HINT = 0;
   // Offsets inside a four-bit condition field
   localparam int COND_LT = 0;
   localparam int COND_GT = 1;
   localparam int COND_EQ = 2;
   localparam int COND_SO = 3;
   localparam int COND_FIELD_W = 4;
   localparam logic [ADDR_W-1:0] INSN_STEP = 32'h0000_0004;
   localparam logic [ADDR_W-1:0] RESET_ADDR = 32'h0000_0000;
   localparam logic [ADDR_W-1:0] RESET_REG = 32'h0000_0000;

   typedef enum logic [1:0] {
      BTRR_FORM_NONE,
      BTRR_FORM_LINK,
      BTRR_FORM_COUNT
   } btrr_form_e;

   // One issued instruction with its address
   typedef struct packed {
      logic valid;
      logic [INSN_W-1:0] insn;
      logic [ADDR_W-1:0] current_address;
   } btrr_issue_s;

   // Resolved branch outcome
   typedef struct packed {
      logic valid;
      logic taken;
      logic hint;
      logic [ADDR_W-1:0] next_address;
   } btrr_result_s;
endpackage

/* File: btrr_decode.sv */
`timescale 1ns/10ps
// Splits an issued word into the branch-to-register fields
module btrr_decode
   import btrr_pkg::*;
(
   input wire logic [INSN_W-1:0] insn,
   output btrr_form_e form,
   output logic [4:0] branch_options,
   output logic [4:0] condition_bit_select,
   output logic link_flag
);
   // Only primary 19 with one of the two extended codes is ours
   always_comb begin
      form = BTRR_FORM_NONE;
      if (insn[OPC_HI:OPC_LO] == OPC_BRANCH_REG) begin
         if (insn[XO_HI:XO_LO] == XO_TO_LINK) begin
            form = BTRR_FORM_LINK;
         end else if (insn[XO_HI:XO_LO] == XO_TO_COUNT) begin
            form = BTRR_FORM_COUNT;
         end
      end
   end

   assign branch_options = insn[OPT_HI:OPT_LO];
   assign condition_bit_select = insn[SEL_HI:SEL_LO];
   assign link_flag = insn[LINK_BIT];
endmodule // btrr_decode

/* File: btrr_cond_eval.sv */
`timescale 1ns/10ps
// Combines the counter test and the condition-bit test
module btrr_cond_eval
   import btrr_pkg::*;
#(
   parameter int CR_W = 32
) (
   input wire logic [4:0] branch_options,
   input wire logic [4:0] condition_bit_select,
   input wire logic [CR_W-1:0] condition_register,
   input wire logic [ADDR_W-1:0] count_register,
   output logic [ADDR_W-1:0] count_next,
   output logic taken
);
   logic count_ok;
   logic cond_ok;
   logic sel_bit;

   // Bit 0 of the selector names the most significant register bit
   assign sel_bit = condition_register[CR_W-1-int'(condition_bit_select)];
   assign count_next = branch_options[OPT_KEEP_COUNT] ? count_register
                       : count_register - 32'h0000_0001;

   // Counter test drops out when the keep-count option is set
   always_comb begin
      if (branch_options[OPT_KEEP_COUNT]) begin
         count_ok = 1'b1;
      end else begin
         count_ok = ((count_next == '0) == branch_options[OPT_ZERO_SENSE]);
      end
   end

   // Condition test drops out when the ignore option is set
   always_comb begin
      if (branch_options[OPT_IGNORE_COND]) begin
         cond_ok = 1'b1;
      end else begin
         cond_ok = (sel_bit == branch_options[OPT_COND_SENSE]);
      end
   end

   assign taken = count_ok & cond_ok;

   // The selector reaches 32 bits only, so a narrower or wider register cannot be served
   if (CR_W != 32) begin : g_width_check
      $error("btrr_cond_eval supports a 32-bit condition register only");
   end
endmodule // btrr_cond_eval

/* File: btrr_resolver.sv */
`timescale 1ns/10ps
module btrr_resolver
   import btrr_pkg::*;
#(
   parameter int CR_W = 32
) (
   input wire logic clk,
   input wire logic rst,
   input wire btrr_pkg::btrr_issue_s issue,
   input wire logic [CR_W-1:0] condition_register,
   input wire logic count_load,
   input wire logic [btrr_pkg::ADDR_W-1:0] count_load_value,
   input wire logic link_load,
   input wire logic [btrr_pkg::ADDR_W-1:0] link_load_value,
   output btrr_pkg::btrr_result_s result,
   output logic [btrr_pkg::ADDR_W-1:0] count_register,
   output logic [btrr_pkg::ADDR_W-1:0] link_register,
   output logic [btrr_pkg::ADDR_W-1:0] resume_address
);
   import btrr_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Decode and evaluate

   btrr_form_e form;
   logic [4:0] branch_options;
   logic [4:0] condition_bit_select;
   logic link_flag;
   logic [ADDR_W-1:0] count_next;
   logic cond_taken;
   logic is_branch;
   logic [ADDR_W-1:0] seq_address;
   logic [ADDR_W-1:0] target;
   logic [ADDR_W-1:0] next_address;
   btrr_result_s result_reg;
   logic [ADDR_W-1:0] count_reg;
   logic [ADDR_W-1:0] link_reg;
   logic [ADDR_W-1:0] resume_reg;

   btrr_decode u_decode (
      .insn(issue.insn),
      .form(form),
      .branch_options(branch_options),
      .condition_bit_select(condition_bit_select),
      .link_flag(link_flag)
   );

   btrr_cond_eval #(
      .CR_W(CR_W)
   ) u_eval (
      .branch_options(branch_options),
      .condition_bit_select(condition_bit_select),
      .condition_register(condition_register),
      .count_register(count_reg),
      .count_next(count_next),
      .taken(cond_taken)
   );

   assign is_branch = issue.valid && (form != BTRR_FORM_NONE);
   assign seq_address = issue.current_address + INSN_STEP;

   // Target from the register held before this cycle's writes
   always_comb begin
      if (form == BTRR_FORM_COUNT) begin
         target = {count_reg[ADDR_W-1:2], 2'b00};
      end else begin
         target = {link_reg[ADDR_W-1:2], 2'b00};
      end
   end

   // Hint is not an input here, so it cannot alter the outcome
   assign next_address = cond_taken ? target : seq_address;

   ////////////////////////////////////////////////////////////////////////////
   // Result and resume point

   // One-cycle result per branch word
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         result_reg <= '0;
      end else begin
         result_reg.valid <= is_branch;
         result_reg.taken <= is_branch & cond_taken;
         result_reg.hint <= is_branch & branch_options[OPT_HINT];
         result_reg.next_address <= next_address;
      end
   end

   // Fetch resumes from here after every resolved branch
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         resume_reg <= RESET_ADDR;
      end else if (is_branch) begin
         resume_reg <= next_address;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Architected counter and link registers

   // Branch decrement overrides an external load in the same cycle;
   // a count-form decrement is undefined, so it is simply performed
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         count_reg <= RESET_REG;
      end else if (is_branch && !branch_options[OPT_KEEP_COUNT]) begin
         count_reg <= count_next;
      end else if (count_load) begin
         count_reg <= count_load_value;
      end
   end

   // Return address written after the target was read
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         link_reg <= RESET_REG;
      end else if (is_branch && link_flag) begin
         link_reg <= seq_address;
      end else if (link_load) begin
         link_reg <= link_load_value;
      end
   end

   assign result = result_reg;
   assign count_register = count_reg;
   assign link_register = link_reg;
   assign resume_address = resume_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   a_not_taken_seq: assert property (@(posedge clk) disable iff (rst)
      is_branch && !cond_taken |=> result.next_address == $past(seq_address))
      else $error("not-taken branch did not go to next word");

   a_link_target: assert property (@(posedge clk) disable iff (rst)
      is_branch && cond_taken && form == BTRR_FORM_LINK
      |=> result.next_address == {$past(link_reg[ADDR_W-1:2]), 2'b00})
      else $error("link target wrong");

   a_count_target: assert property (@(posedge clk) disable iff (rst)
      is_branch && cond_taken && form == BTRR_FORM_COUNT
      |=> result.next_address == {$past(count_reg[ADDR_W-1:2]), 2'b00})
      else $error("count target wrong");

   a_count_decr: assert property (@(posedge clk) disable iff (rst)
      is_branch && !branch_options[OPT_KEEP_COUNT]
      |=> count_register == $past(count_reg) - 32'h0000_0001)
      else $error("counter not decremented");

   a_count_keep: assert property (@(posedge clk) disable iff (rst)
      is_branch && branch_options[OPT_KEEP_COUNT] && !count_load
      |=> $stable(count_register))
      else $error("counter changed without decrement");

   a_link_save: assert property (@(posedge clk) disable iff (rst)
      is_branch && link_flag |=> link_register == $past(issue.current_address) + 32'h4)
      else $error("return address not saved");

   a_uncond_taken: assert property (@(posedge clk) disable iff (rst)
      is_branch && branch_options == 5'h14 |=> result.taken)
      else $error("option 20 not taken");

   a_cond_only: assert property (@(posedge clk) disable iff (rst)
      is_branch && branch_options == 5'h0c
      |=> result.taken == $past(condition_register[CR_W-1-int'(condition_bit_select)]))
      else $error("option 12 outcome wrong");

   a_bnz_taken: assert property (@(posedge clk) disable iff (rst)
      is_branch && branch_options == 5'h10 |=> result.taken == (count_register != '0))
      else $error("option 16 outcome wrong");

   a_bz_cond: assert property (@(posedge clk) disable iff (rst)
      is_branch && branch_options == 5'h0a
      |=> result.taken == ((count_register == '0)
          && $past(condition_register[CR_W-1-int'(condition_bit_select)])))
      else $error("option 10 outcome wrong");

   a_resume_next: assert property (@(posedge clk) disable iff (rst)
      result.valid |-> resume_address == result.next_address)
      else $error("resume point differs from next address");

   ////////////////////////////////////////////////////////////////////////////
   // Further checks on the option encodings and on refused words

   // Selected condition bit, bit 0 of the selector naming the top register bit.
   // Kept apart from the evaluator so the checks below do not lean on its wiring.
   logic chk_sel_bit;
   assign chk_sel_bit = condition_register[CR_W-1-int'(condition_bit_select)];

   // The evaluator reaches 32 bits only; refuse anything else at elaboration
   if (CR_W != 32) begin : g_width_check
      $error("btrr_resolver supports a 32-bit condition register only");
   end

   a_bdz_taken: assert property (
      @(posedge clk) disable iff (rst)
      is_branch && branch_options == 5'h12
      |=> result.taken == (count_register == '0))
      else $error("option 18 outcome wrong");

   a_bnz_false: assert property (
      @(posedge clk) disable iff (rst)
      is_branch && branch_options == 5'h00
      |=> result.taken == ((count_register != '0) && !$past(chk_sel_bit)))
      else $error("option 0 outcome wrong");

   a_bnz_true: assert property (
      @(posedge clk) disable iff (rst)
      is_branch && branch_options == 5'h08
      |=> result.taken == ((count_register != '0) && $past(chk_sel_bit)))
      else $error("option 8 outcome wrong");

   a_bz_false: assert property (
      @(posedge clk) disable iff (rst)
      is_branch && branch_options == 5'h02
      |=> result.taken == ((count_register == '0) && !$past(chk_sel_bit)))
      else $error("option 2 outcome wrong");

   a_false_only: assert property (
      @(posedge clk) disable iff (rst)
      is_branch && branch_options == 5'h04
      |=> result.taken == !$past(chk_sel_bit))
      else $error("option 4 outcome wrong");

   a_ignore_cond: assert property (
      @(posedge clk) disable iff (rst)
      is_branch && branch_options[OPT_IGNORE_COND] && branch_options[OPT_KEEP_COUNT]
      |=> result.taken)
      else $error("ignored condition still blocked the branch");

   a_keep_cond: assert property (
      @(posedge clk) disable iff (rst)
      is_branch && branch_options[OPT_KEEP_COUNT] && !branch_options[OPT_IGNORE_COND]
      |=> result.taken == ($past(chk_sel_bit) == $past(branch_options[OPT_COND_SENSE])))
      else $error("kept counter still affected the outcome");

   a_cond_sense: assert property (
      @(posedge clk) disable iff (rst)
      is_branch && !branch_options[OPT_IGNORE_COND] && chk_sel_bit != branch_options[OPT_COND_SENSE]
      |=> !result.taken)
      else $error("condition mismatch still taken");

   a_zero_sense: assert property (
      @(posedge clk) disable iff (rst)
      is_branch && !branch_options[OPT_KEEP_COUNT]
      |=> !result.taken || ((count_register == '0) == $past(branch_options[OPT_ZERO_SENSE])))
      else $error("counter test failed but branch taken");

   a_hint_pass: assert property (
      @(posedge clk) disable iff (rst)
      is_branch
      |=> result.hint == $past(branch_options[OPT_HINT]))
      else $error("hint not passed on");

   a_refuse_word: assert property (
      @(posedge clk) disable iff (rst)
      !is_branch
      |=> !result.valid)
      else $error("refused word produced a result");

   a_refuse_count: assert property (
      @(posedge clk) disable iff (rst)
      !is_branch && !count_load
      |=> $stable(count_register))
      else $error("refused word changed the counter");

   a_link_keep: assert property (
      @(posedge clk) disable iff (rst)
      !(is_branch && link_flag) && !link_load
      |=> $stable(link_register))
      else $error("link register changed without a save or load");

   a_link_before: assert property (
      @(posedge clk) disable iff (rst)
      is_branch && cond_taken && link_flag && form == BTRR_FORM_LINK
      |=> result.next_address == {$past(link_reg[ADDR_W-1:2]), 2'b00})
      else $error("link target used the saved return address");

   a_count_form: assert property (
      @(posedge clk) disable iff (rst)
      is_branch && form == BTRR_FORM_COUNT && branch_options == 5'h14
      |=> result.taken && result.next_address == {$past(count_reg[ADDR_W-1:2]), 2'b00})
      else $error("count form unconditional branch wrong");

   a_target_align: assert property (
      @(posedge clk) disable iff (rst)
      result.valid && result.taken
      |-> result.next_address[1:0] == 2'b00)
      else $error("taken target not word aligned");

   a_count_load: assert property (
      @(posedge clk) disable iff (rst)
      !(is_branch && !branch_options[OPT_KEEP_COUNT]) && count_load
      |=> count_register == $past(count_load_value))
      else $error("counter load lost");

   a_link_load: assert property (
      @(posedge clk) disable iff (rst)
      !(is_branch && link_flag) && link_load
      |=> link_register == $past(link_load_value))
      else $error("link load lost");

   a_field_eq: assert property (
      @(posedge clk) disable iff (rst)
      is_branch && branch_options == 5'h0c && condition_bit_select == 5'h02
      |=> result.taken == $past(condition_register[CR_W-1-COND_EQ]))
      else $error("equal bit of field zero not selected");

   // A refused word must leave the resume point where the last branch put it
   a_resume_hold: assert property (
      @(posedge clk) disable iff (rst)
      !is_branch
      |=> $stable(resume_address))
      else $error("resume point moved without a branch");
endmodule // btrr_resolver

/* File: btrr_issue_model.sv */
`timescale 1ns/10ps
// Issue stage stand-in: forwards one slot per cycle, no stalls
module btrr_issue_model
   import btrr_pkg::*;
(
   input wire logic clk,
   input wire btrr_pkg::btrr_issue_s req,
   output btrr_pkg::btrr_issue_s issue
);
   logic [INSN_W+ADDR_W-1:0] idle_reg;
   // Idle slots carry a changing pattern, so stale fields never pass for real ones
   always_ff @(posedge clk) begin
      idle_reg <= ~{req.insn, req.current_address};
   end
   always_comb begin
      issue = req.valid ? req : {1'b0, idle_reg};
   end
endmodule // btrr_issue_model

/* File: branch_to_register_resolver_bench.sv */
`timescale 1ns/10ps
module branch_to_register_resolver_bench;
   import btrr_pkg::*;
   typedef struct packed {
      logic taken;
      logic hint;
      logic [31:0] nxt;
      logic [31:0] c;
      logic [31:0] l;
   } btrr_note_s;
   logic clk = 1'b0;
   logic rst = 1'b1;
   btrr_issue_s req;
   btrr_issue_s issue;
   btrr_result_s result;
   logic [31:0] cr, cl_v, ll_v, ctr, lr, res_addr;
   logic cl, ll;
   int fails = 0;
   int samples_checked = 0;
   btrr_note_s q[$];
   btrr_note_s n;
   logic [31:0] m_ctr = 32'h0;
   logic [31:0] m_lr = 32'h0;
   logic [4:0] opts[9] = '{5'h00, 5'h02, 5'h04, 5'h08, 5'h0a, 5'h0c, 5'h10, 5'h12, 5'h14};

   always #5 clk = ~clk;

   btrr_issue_model i_btrr_issue_model (.clk(clk), .req(req), .issue(issue));
   btrr_resolver i_btrr_resolver (.clk(clk), .rst(rst), .issue(issue),
      .condition_register(cr), .count_load(cl), .count_load_value(cl_v),
      .link_load(ll), .link_load_value(ll_v), .result(result),
      .count_register(ctr), .link_register(lr), .resume_address(res_addr));

   ////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic stop_test;
      $display("fails=%0d samples_checked=%0d", fails, samples_checked);
      if (fails == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Kind 0 idle, 1 link form, 2 count form, 3 other valid word
   task automatic issue_one(input int kind);
      logic [4:0] o, s;
      logic [31:0] w, a, c, c_n, tgt;
      logic tk, k;
      @(posedge clk);
      c = $urandom;
      a = $urandom & 32'hffff_fffc;
      o = opts[$urandom % 9] | 5'($urandom % 2);
      // Decrement with counter target is undefined, so count form keeps the counter
      if (kind == 2) o[2] = 1'b1;
      s = 5'($urandom);
      w = {OPC_BRANCH_REG, o, s, 5'h00, (kind == 2) ? XO_TO_COUNT : XO_TO_LINK, 1'($urandom)};
      if (kind == 3) w[10:1] = 10'h011;
      req <= '{(kind != 0), w, a};
      cr <= c;
      cl <= 1'($urandom);
      ll <= 1'($urandom);
      // Small load values make the zero test of the counter come up often
      cl_v <= $urandom % 4;
      ll_v <= $urandom;
      #1;
      if (kind == 1 || kind == 2) begin
         k = o[2];
         c_n = k ? m_ctr : m_ctr - 32'h1;
         tk = (k | ((c_n == 32'h0) == o[1])) & (o[4] | (c[31-s] == o[3]));
         tgt = ((kind == 1) ? m_lr : m_ctr) & 32'hffff_fffc;
         q.push_back('{tk, o[0], tk ? tgt : a + 32'h4,
            k ? (cl ? cl_v : m_ctr) : c_n, w[0] ? a + 32'h4 : (ll ? ll_v : m_lr)});
         m_ctr = q[$].c;
         m_lr = q[$].l;
      end else begin
         m_ctr = cl ? cl_v : m_ctr;
         m_lr = ll ? ll_v : m_lr;
      end
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Watcher: settled outputs between edges, one note per result pulse
   always @(negedge clk) begin
      if (!rst && result.valid === 1'b1) begin
         if (q.size() == 0) begin
            check(32'h1, 32'h0);
         end else begin
            n = q.pop_front();
            check(result.taken, n.taken);
            check(result.hint, n.hint);
            check(result.next_address, n.nxt);
            check(res_addr, n.nxt);
            check(ctr, n.c);
            check(lr, n.l);
         end
      end
   end

   initial begin
      req = '0;
      cr = 32'h0;
      cl = 1'b0;
      ll = 1'b0;
      cl_v = 32'h0;
      ll_v = 32'h0;
      void'($urandom(46));
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      check(ctr, RESET_REG);
      check(lr, RESET_REG);
      check(res_addr, RESET_ADDR);
      // Back to back random mix of forms, options, selectors and refused words
      for (int i = 0; i < 800; i++) begin
         issue_one($urandom % 4);
      end
      issue_one(0);
      repeat (3) @(posedge clk);
      check(q.size(), 32'h0);
      stop_test();
   end

   // Watchdog well beyond the roughly 800 cycles the run needs
   initial begin
      #50000;
      fails++;
      stop_test();
   end
endmodule // branch_to_register_resolver_bench
